/* File: verilog/msled_regs.svh */
// Timing constants for the module status LED encoder
`ifndef MSLED_REGS_SVH
`define MSLED_REGS_SVH
`define MSLED_CLK_HZ      125000000
`define MSLED_SLOW_HZ     1
`define MSLED_FAST_HZ     8
// Half period in cycles: clock / (2 * rate)
`define MSLED_SLOW_HALF   (`MSLED_CLK_HZ / (2 * `MSLED_SLOW_HZ))
`define MSLED_FAST_HALF   (`MSLED_CLK_HZ / (2 * `MSLED_FAST_HZ))
`define MSLED_ALT_HALF    (`MSLED_CLK_HZ / (2 * `MSLED_FAST_HZ))
`define MSLED_LED_OFF     2'h0
`endif

/* File: verilog/msled_pkg.sv */
// Types for the module status LED encoder
package msled_pkg;
  typedef enum logic [1:0] {
    MSLED_OFF    = 2'h0,
    MSLED_GREEN  = 2'h1,
    MSLED_YELLOW = 2'h2,
    MSLED_RED    = 2'h3
  } msled_colour_t;

  typedef enum logic [7:0] {
    MSLED_ST_ACTIVE   = 8'h01,
    MSLED_ST_APPNA    = 8'h02,
    MSLED_ST_READY    = 8'h04,
    MSLED_ST_CONN     = 8'h08,
    MSLED_ST_CFGDIFF  = 8'h10,
    MSLED_ST_PREVLOST = 8'h20,
    MSLED_ST_NOTCONN  = 8'h40,
    MSLED_ST_RESET    = 8'h80
  } msled_state_t;
endpackage

/* File: verilog/msled_blinker.sv */
// Square wave prescaler with 50 percent duty
`timescale 1ns/10ps
`include "msled_regs.svh"
module msled_blinker #(
  parameter int HALF_CYCLES = 8
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  output logic      phase
);
  localparam int CW = $clog2(HALF_CYCLES + 1);
  logic [CW-1:0] count_r;
  wire           wrap = (count_r == CW'(HALF_CYCLES - 1));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= '0;
      phase   <= 1'b0;
    end else begin
      count_r <= wrap ? '0 : count_r + CW'(1);
      if (wrap) begin
        phase <= ~phase;
      end
    end
  end

  property p_half_period;
    @(posedge sys_clk) disable iff (!reset_n)
      wrap |=> (phase != $past(phase));
  endproperty
  a_half_period: assert property (p_half_period) else $error("blinker phase did not toggle at wrap");  // see RULE15
endmodule

/* File: verilog/msled_encoder.sv */
// Module status LED encoder: state detection and colour pattern
// How it works
// RULE1: Operational, comms good, process data invalid, no fault: flash green.
// RULE2: Slot configured for passive element also flashes green.
// RULE3: Comms good, data valid, I/O fault: alternate green and yellow.
// RULE4: In application-not-active, outputs not drivable and inputs not readable.
// RULE5: Operational with no local bus cycle since power-up: steady yellow.
// RULE6: Ready is left at the first local bus cycle.
// RULE7: Not in active configuration: flash yellow slowly (1 Hz).
// RULE8: Preceding slot element absent or passive during power-up: connected indication.
// RULE9: Configuration difference: flash yellow fast (8 Hz).
// RULE10: Unconfigured element inserted raises the fast yellow indication.
// RULE11: Preceding element lost backplane during operation: alternate yellow and red.
// RULE12: Operational with no link to preceding module: flash red.
// RULE13: Existing link to preceding module lost: steady red.
// RULE14: One indication at a time; red first, then configuration, then others.
// RULE15: Flashing uses 50 percent duty from prescaler; two-colour alternates per half.
`timescale 1ns/10ps
`include "msled_regs.svh"
module msled_encoder #(
  parameter int SLOW_HALF = `MSLED_SLOW_HALF,
  parameter int FAST_HALF = `MSLED_FAST_HALF
) (
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  input  wire logic                    operational,
  input  wire logic                    comm_ok,
  input  wire logic                    pd_valid,
  input  wire logic                    io_fault,
  input  wire logic                    slot_passive,
  input  wire logic                    bus_cycle,
  input  wire logic                    in_config,
  input  wire logic                    powering_up,
  input  wire logic                    prev_absent,
  input  wire logic                    cfg_diff,
  input  wire logic                    unconf_inserted,
  input  wire logic                    prev_lost,
  input  wire logic                    link_up,
  output msled_pkg::msled_colour_t     led_colour,
  output msled_pkg::msled_state_t      led_state,
  output logic                         out_enable,
  output logic                         in_enable
);
  import msled_pkg::*;

  logic         seen_cycle_r;
  logic         had_link_r;
  msled_state_t state_r;
  msled_state_t state_nxt;
  msled_colour_t colour_r;
  msled_colour_t colour_nxt;
  logic         slow_ph;
  logic         fast_ph;

  msled_blinker #(.HALF_CYCLES(SLOW_HALF)) u_slow (  // see RULE15
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .phase   (slow_ph)
  );
  msled_blinker #(.HALF_CYCLES(FAST_HALF)) u_fast (  // see RULE15
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .phase   (fast_ph)
  );

  // Condition decode
  wire no_link     = operational && !link_up && !had_link_r;             // see RULE12
  wire link_lost   = operational && !link_up && had_link_r;              // see RULE13
  wire prev_gone   = operational && prev_lost;                           // see RULE11
  wire diff_seen   = cfg_diff || unconf_inserted;                        // see RULE9 see RULE10
  wire not_member  = !in_config || (powering_up && prev_absent);         // see RULE7 see RULE8
  wire not_ready   = operational && !seen_cycle_r && !bus_cycle;         // see RULE5 see RULE6
  wire app_na      = comm_ok && pd_valid && io_fault;                    // see RULE3
  wire passive_slot = slot_passive;                                      // see RULE2

  // Priority: red link states, then configuration, then the rest
  always_comb begin  // see RULE14
    if (link_lost) begin
      state_nxt = MSLED_ST_RESET;
    end else if (no_link) begin
      state_nxt = MSLED_ST_NOTCONN;
    end else if (prev_gone) begin
      state_nxt = MSLED_ST_PREVLOST;
    end else if (diff_seen) begin
      state_nxt = MSLED_ST_CFGDIFF;
    end else if (not_member) begin
      state_nxt = MSLED_ST_CONN;
    end else if (passive_slot) begin
      // Passive slot has no process I/O, so it shows active ahead of ready
      state_nxt = MSLED_ST_ACTIVE;                                       // see RULE2
    end else if (not_ready) begin
      state_nxt = MSLED_ST_READY;
    end else if (app_na) begin
      state_nxt = MSLED_ST_APPNA;
    end else begin
      state_nxt = MSLED_ST_ACTIVE;                                       // see RULE1 see RULE2
    end
  end

  // Colour selection from the held state
  always_comb begin
    case (state_r)
      MSLED_ST_ACTIVE:   colour_nxt = fast_ph ? MSLED_GREEN : MSLED_OFF;      // see RULE1
      MSLED_ST_APPNA:    colour_nxt = fast_ph ? MSLED_GREEN : MSLED_YELLOW;   // see RULE3
      MSLED_ST_READY:    colour_nxt = MSLED_YELLOW;                           // see RULE5
      MSLED_ST_CONN:     colour_nxt = slow_ph ? MSLED_YELLOW : MSLED_OFF;     // see RULE7
      MSLED_ST_CFGDIFF:  colour_nxt = fast_ph ? MSLED_YELLOW : MSLED_OFF;     // see RULE9
      MSLED_ST_PREVLOST: colour_nxt = fast_ph ? MSLED_YELLOW : MSLED_RED;     // see RULE11
      MSLED_ST_NOTCONN:  colour_nxt = fast_ph ? MSLED_RED : MSLED_OFF;        // see RULE12
      MSLED_ST_RESET:    colour_nxt = MSLED_RED;                              // see RULE13
      default:           colour_nxt = MSLED_OFF;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      seen_cycle_r <= 1'b0;
      had_link_r   <= 1'b0;
      state_r      <= MSLED_ST_READY;
      colour_r     <= MSLED_OFF;
    end else begin
      seen_cycle_r <= seen_cycle_r | bus_cycle;                          // see RULE6
      had_link_r   <= had_link_r | link_up;
      state_r      <= state_nxt;
      colour_r     <= colour_nxt;
    end
  end

  assign led_colour = colour_r;
  assign led_state  = state_r;
  assign out_enable = (state_r != MSLED_ST_APPNA);                       // see RULE4
  assign in_enable  = (state_r != MSLED_ST_APPNA);                       // see RULE4

  property p_reset_red;
    @(posedge sys_clk) disable iff (!reset_n)
      link_lost |=> ##1 (led_colour == MSLED_RED);
  endproperty
  a_reset_red: assert property (p_reset_red) else $error("link loss not steady red");  // see RULE13

  property p_ready_yellow;
    @(posedge sys_clk) disable iff (!reset_n)
      (state_r == MSLED_ST_READY) |=> (led_colour == MSLED_YELLOW);
  endproperty
  a_ready_yellow: assert property (p_ready_yellow) else $error("ready not steady yellow");  // see RULE5

  property p_leave_ready;
    @(posedge sys_clk) disable iff (!reset_n)
      bus_cycle |=> ##1 (state_r != MSLED_ST_READY);
  endproperty
  a_leave_ready: assert property (p_leave_ready) else $error("ready held after bus cycle");  // see RULE6

  property p_priority;
    @(posedge sys_clk) disable iff (!reset_n)
      (no_link && diff_seen) |=> (state_r == MSLED_ST_NOTCONN);
  endproperty
  a_priority: assert property (p_priority) else $error("red link state not given priority");  // see RULE14

  property p_cfgdiff;
    @(posedge sys_clk) disable iff (!reset_n)
      (diff_seen && !link_lost && !no_link && !prev_gone) |=> (state_r == MSLED_ST_CFGDIFF);
  endproperty
  a_cfgdiff: assert property (p_cfgdiff) else $error("configuration difference not shown");  // see RULE9

  property p_appna_gate;
    @(posedge sys_clk) disable iff (!reset_n)
      (app_na && !link_lost && !no_link && !prev_gone && !diff_seen && !not_member && !passive_slot && !not_ready)
        |=> (!out_enable && !in_enable);
  endproperty
  a_appna_gate: assert property (p_appna_gate) else $error("process I/O enabled in app not active");  // see RULE4

  property p_appna_colour;
    @(posedge sys_clk) disable iff (!reset_n)
      (state_r == MSLED_ST_APPNA) |=> (led_colour inside {MSLED_GREEN, MSLED_YELLOW});
  endproperty
  a_appna_colour: assert property (p_appna_colour) else $error("app not active colour wrong");  // see RULE3

  property p_prevlost;
    @(posedge sys_clk) disable iff (!reset_n)
      (state_r == MSLED_ST_PREVLOST) |=> (led_colour inside {MSLED_YELLOW, MSLED_RED});
  endproperty
  a_prevlost: assert property (p_prevlost) else $error("preceding loss colour wrong");  // see RULE11

  property p_active_green;
    @(posedge sys_clk) disable iff (!reset_n)
      (state_r == MSLED_ST_ACTIVE) |=> (led_colour inside {MSLED_GREEN, MSLED_OFF});
  endproperty
  a_active_green: assert property (p_active_green) else $error("active colour wrong");  // see RULE1

  c_active:  cover property (@(posedge sys_clk) state_r == MSLED_ST_ACTIVE);
  c_reset:   cover property (@(posedge sys_clk) state_r == MSLED_ST_RESET);
  c_cfgdiff: cover property (@(posedge sys_clk) state_r == MSLED_ST_CFGDIFF);
  c_appna:   cover property (@(posedge sys_clk) state_r == MSLED_ST_APPNA);
endmodule

/* File: tb/msled_ctrl_model.sv */
// Station controller stand-in: local bus cycles and process data flags
`timescale 1ns/10ps
module msled_ctrl_model (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic run,
  input  wire logic data_ok,
  output logic      bus_cycle,
  output logic      comm_ok,
  output logic      pd_valid
);
  logic [1:0] gap_r;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_r     <= 2'h0;
      bus_cycle <= 1'b0;
    end else begin
      gap_r     <= gap_r + 2'h1;
      bus_cycle <= run && (gap_r == 2'h3);
    end
  end
  // Silent controller keeps both flags low
  assign comm_ok  = run;
  assign pd_valid = run && data_ok;
endmodule

/* File: tb/msled_encoder_tb.sv */
// Self-checking bench for the module status LED encoder
`timescale 1ns/10ps
module msled_encoder_tb;
  import msled_pkg::*;
  logic          sys_clk, reset_n, bus_cycle, comm_ok, pd_valid, out_enable, in_enable, seen, had;
  logic [11:0]   v;
  logic [3:0]    mask;
  msled_colour_t led_colour;
  msled_state_t  led_state;
  int            failures, check_count, cyc;
  msled_ctrl_model PARTNER (.sys_clk(sys_clk), .reset_n(reset_n), .run(v[10]), .data_ok(v[11]),
    .bus_cycle(bus_cycle), .comm_ok(comm_ok), .pd_valid(pd_valid));
  msled_encoder #(.SLOW_HALF(8), .FAST_HALF(2)) DUT (.sys_clk(sys_clk), .reset_n(reset_n),
    .operational(v[0]), .comm_ok(comm_ok), .pd_valid(pd_valid), .io_fault(v[1]), .slot_passive(v[2]),
    .bus_cycle(bus_cycle), .in_config(v[3]), .powering_up(v[4]), .prev_absent(v[5]), .cfg_diff(v[6]),
    .unconf_inserted(v[7]), .prev_lost(v[8]), .link_up(v[9]), .led_colour(led_colour),
    .led_state(led_state), .out_enable(out_enable), .in_enable(in_enable));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      tally_and_finish();
    end
  end
  function automatic logic [7:0] ref_state(logic [11:0] x, logic s, logic h);
    if (!x[9]) return h ? 8'h80 : 8'h40;
    if (x[8]) return 8'h20;
    if (x[6] || x[7]) return 8'h10;
    if (!x[3] || (x[4] && x[5])) return 8'h08;
    if (x[2]) return 8'h01;
    if (x[0] && !s) return 8'h04;
    if (x[10] && x[11] && x[1]) return 8'h02;
    return 8'h01;
  endfunction
  // Colours seen in a window, bit index is the colour code
  function automatic logic [3:0] ref_mask(logic [7:0] s);
    case (s)
      8'h01: return 4'h3;
      8'h02: return 4'h6;
      8'h04: return 4'h4;
      8'h08, 8'h10: return 4'h5;
      8'h20: return 4'hC;
      8'h40: return 4'h9;
      default: return 4'h8;
    endcase
  endfunction
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apply(input logic [11:0] x);
    logic [7:0] es;
    @(posedge sys_clk) #1 v = x;
    seen |= x[10];
    had |= x[9];
    repeat (8) @(posedge sys_clk);
    es = ref_state(x, seen, had);
    mask = 4'h0;
    repeat (40) begin
      @(posedge sys_clk) #2;
      mask[led_colour] = 1'b1;
    end
    check("led_state", es, led_state);
    check("colour_set", {4'h0, ref_mask(es)}, {4'h0, mask});
    check("out_enable", {7'h0, es != 8'h02}, {7'h0, out_enable});
    check("in_enable", {7'h0, es != 8'h02}, {7'h0, in_enable});
    $display("test %h done", x);
  endtask
  task automatic do_reset();
    #1 reset_n = 1'b0;
    seen = 1'b0;
    had = 1'b0;
    repeat (8) @(posedge sys_clk);
    check("reset_state", 8'h04, led_state);
    #1 reset_n = 1'b1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    logic [11:0] r;
    reset_n = 1'b0;
    v = 12'h000;
    void'($urandom(72157));
    do_reset();
    apply(12'h209);
    apply(12'h609);
    apply(12'h60D);
    apply(12'hE0B);
    apply(12'hE09);
    apply(12'h601);
    apply(12'h639);
    apply(12'h649);
    apply(12'h689);
    apply(12'h709);
    apply(12'h749);
    apply(12'h401);
    do_reset();
    apply(12'h001);
    apply(12'h041);
    apply(12'h20D);
    apply(12'h209);
    repeat (24) begin
      r = 12'($urandom);
      r[0] = 1'b1;
      apply(r);
    end
    tally_and_finish();
  end
endmodule
